// [lockstep_ecc_defs.vh]
// Constants for the lock-step and ECC protection block
`ifndef LOCKSTEP_ECC_DEFS_VH
`define LOCKSTEP_ECC_DEFS_VH

// RAM word widths, data part and check part
`define DTAG_DATA_W 26
`define DTAG_CHK_W 7
`define DDATA_DATA_W 32
`define DDATA_CHK_W 7
`define ITAG_DATA_W 22
`define ITAG_CHK_W 7
`define IDATA_DATA_W 64
`define IDATA_CHK_W 8

// Hamming part of the 32-bit code and its overall parity bit position
`define HAM_W 6
`define HAM_LAST_POS 38
`define PAR_POS 38

// Redundant core lag in clock cycles
`define CORE_LAG 2
// Joint reset pulse length in clock cycles
`define JOINT_RST_CYCLES 4

`endif

// [lockstep_ecc_protection.v]
// Lock-step comparator and ECC read-modify-write for the data cache RAM
`timescale 1ns/1ps
`include "lockstep_ecc_defs.vh"

module lockstep_ecc_protection #(
	parameter ADDR_W = 3,
	parameter IN_W = 32,
	parameter OUT_W = 32,
	parameter LAG = `CORE_LAG,
	parameter RST_CYCLES = `JOINT_RST_CYCLES
) (
	input wire clk,
	input wire rst,
	input wire st_req,
	input wire [ADDR_W-1:0] st_addr,
	input wire [`DDATA_DATA_W-1:0] st_wdata,
	input wire [3:0] st_be,
	output wire st_ready,
	input wire ld_req,
	input wire [ADDR_W-1:0] ld_addr,
	output wire ld_ready,
	output reg ld_valid,
	output reg [`DDATA_DATA_W-1:0] ld_data,
	output reg ld_single_err,
	output reg ld_double_err,
	output reg rmw_double_err,
	output reg ram_en,
	output reg ram_we,
	output reg [ADDR_W-1:0] ram_addr,
	output reg [`DDATA_DATA_W+`DDATA_CHK_W-1:0] ram_wdata,
	input wire [`DDATA_DATA_W+`DDATA_CHK_W-1:0] ram_rdata,
	input wire [IN_W-1:0] pin_in,
	output wire [IN_W-1:0] red_in,
	input wire [OUT_W-1:0] pri_out,
	input wire [OUT_W-1:0] red_out,
	output reg mismatch,
	output reg core_rst
);
	localparam WORD_W = `DDATA_DATA_W + `DDATA_CHK_W;
	localparam ST_IDLE = 5'h01;
	localparam ST_LD_A = 5'h02;
	localparam ST_LD_D = 5'h04;
	localparam ST_RMW_A = 5'h08;
	localparam ST_RMW_D = 5'h10;

	// Hamming bits over positions 1..38 plus overall parity in bit 6
	function [`DDATA_CHK_W-1:0] ecc_gen;
		input [`DDATA_DATA_W-1:0] d;
		integer pos;
		integer j;
		integer k;
		reg [`HAM_W-1:0] h;
		begin
			h = {`HAM_W{1'b0}};
			j = 0;
			for (pos = 1; pos <= `HAM_LAST_POS; pos = pos + 1) begin
				if ((pos & (pos - 1)) != 0) begin
					for (k = 0; k < `HAM_W; k = k + 1) begin
						if (pos[k])
							h[k] = h[k] ^ d[j];
					end
					j = j + 1;
				end
			end
			ecc_gen = {(^d) ^ (^h), h};
		end
	endfunction

	// Returns {double, single, corrected data}
	function [`DDATA_DATA_W+1:0] ecc_fix;
		input [WORD_W-1:0] w;
		integer pos;
		integer j;
		reg [`DDATA_DATA_W-1:0] d;
		reg [`HAM_W-1:0] syn;
		reg par_bad;
		reg [`DDATA_CHK_W-1:0] gen;
		begin
			d = w[`DDATA_DATA_W-1:0];
			gen = ecc_gen(d);
			syn = w[WORD_W-2:`DDATA_DATA_W] ^ gen[`HAM_W-1:0];
			par_bad = ^w;
			j = 0;
			for (pos = 1; pos <= `HAM_LAST_POS; pos = pos + 1) begin
				if ((pos & (pos - 1)) != 0) begin
					if (par_bad && syn == pos[`HAM_W-1:0])
						d[j] = ~d[j];
					j = j + 1;
				end
			end
			ecc_fix = {(syn != {`HAM_W{1'b0}}) & ~par_bad, par_bad, d};
		end
	endfunction

	reg [4:0] state_r;
	reg [ADDR_W-1:0] hold_addr_r;
	reg [`DDATA_DATA_W-1:0] hold_data_r;
	reg [3:0] hold_be_r;
	wire [`DDATA_DATA_W+1:0] fix;
	wire [`DDATA_DATA_W-1:0] merged;
	wire full_word;

	assign fix = ecc_fix(ram_rdata);
	assign full_word = (st_be == 4'hf);
	assign st_ready = state_r[0];
	assign ld_ready = state_r[0] & ~st_req;

	genvar b;
	generate
		for (b = 0; b < 4; b = b + 1) begin : g_merge
			assign merged[8*b+7:8*b] = hold_be_r[b] ?
				hold_data_r[8*b+7:8*b] : fix[8*b+7:8*b];
		end
	endgenerate

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			hold_addr_r <= {ADDR_W{1'b0}};
			hold_data_r <= {`DDATA_DATA_W{1'b0}};
			hold_be_r <= 4'h0;
			ram_en <= 1'b0;
			ram_we <= 1'b0;
			ram_addr <= {ADDR_W{1'b0}};
			ram_wdata <= {WORD_W{1'b0}};
			ld_valid <= 1'b0;
			ld_data <= {`DDATA_DATA_W{1'b0}};
			ld_single_err <= 1'b0;
			ld_double_err <= 1'b0;
			rmw_double_err <= 1'b0;
		end else begin
			ram_en <= 1'b0;
			ram_we <= 1'b0;
			ld_valid <= 1'b0;
			rmw_double_err <= 1'b0;
			case (state_r)
			ST_IDLE: begin
				if (st_req && full_word) begin
					ram_en <= 1'b1;
					ram_we <= 1'b1;
					ram_addr <= st_addr;
					ram_wdata <= {ecc_gen(st_wdata), st_wdata};
				end else if (st_req) begin
					ram_en <= 1'b1;
					ram_addr <= st_addr;
					hold_addr_r <= st_addr;
					hold_data_r <= st_wdata;
					hold_be_r <= st_be;
					state_r <= ST_RMW_A;
				end else if (ld_req) begin
					ram_en <= 1'b1;
					ram_addr <= ld_addr;
					state_r <= ST_LD_A;
				end
			end
			ST_LD_A: state_r <= ST_LD_D;
			ST_LD_D: begin
				ld_valid <= 1'b1;
				ld_data <= fix[`DDATA_DATA_W-1:0];
				ld_single_err <= fix[`DDATA_DATA_W];
				ld_double_err <= fix[`DDATA_DATA_W+1];
				state_r <= ST_IDLE;
			end
			ST_RMW_A: state_r <= ST_RMW_D;
			ST_RMW_D: begin
				// Uncorrectable old word is not merged or written back
				if (fix[`DDATA_DATA_W+1]) begin
					rmw_double_err <= 1'b1;
				end else begin
					ram_en <= 1'b1;
					ram_we <= 1'b1;
					ram_addr <= hold_addr_r;
					ram_wdata <= {ecc_gen(merged), merged};
				end
				state_r <= ST_IDLE;
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Lag lines: shared pins to redundant core, primary outputs to compare
	genvar s;
	generate
		for (s = 0; s < LAG; s = s + 1) begin : g_lag
			reg [IN_W-1:0] in_r;
			reg [OUT_W-1:0] out_r;
			wire [IN_W-1:0] in_src;
			wire [OUT_W-1:0] out_src;
			if (s == 0) begin : g_head
				assign in_src = pin_in;
				assign out_src = pri_out;
			end else begin : g_tail
				assign in_src = g_lag[s-1].in_r;
				assign out_src = g_lag[s-1].out_r;
			end
			always @(posedge clk or posedge rst) begin
				if (rst) begin
					in_r <= {IN_W{1'b0}};
					out_r <= {OUT_W{1'b0}};
				end else begin
					in_r <= in_src;
					out_r <= out_src;
				end
			end
		end
	endgenerate
	wire [OUT_W-1:0] pri_late;
	assign red_in = g_lag[LAG-1].in_r;
	assign pri_late = g_lag[LAG-1].out_r;

	reg [7:0] warm_r;
	reg [7:0] rst_cnt_r;
	wire cmp_en;
	wire differ;
	assign cmp_en = (warm_r == LAG[7:0]) & ~core_rst;
	assign differ = cmp_en & (pri_late != red_out);

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			warm_r <= 8'h00;
			rst_cnt_r <= 8'h00;
			mismatch <= 1'b0;
			core_rst <= 1'b0;
		end else begin
			if (core_rst)
				warm_r <= 8'h00;
			else if (warm_r != LAG[7:0])
				warm_r <= warm_r + 8'h01;
			if (differ) begin
				mismatch <= 1'b1;
				core_rst <= 1'b1;
				rst_cnt_r <= RST_CYCLES[7:0] - 8'h01;
			end else if (core_rst) begin
				if (rst_cnt_r == 8'h00) begin
					core_rst <= 1'b0;
					mismatch <= 1'b0;
				end else begin
					rst_cnt_r <= rst_cnt_r - 8'h01;
				end
			end
		end
	end
endmodule // lockstep_ecc_protection

// [lockstep_ecc_props.sv]
// Assertion checker for the lock-step ECC block
`timescale 1ns/1ps
module lockstep_ecc_props (
	input wire clk,
	input wire rst,
	input wire st_req,
	input wire [3:0] st_be,
	input wire st_ready,
	input wire ld_req,
	input wire ld_ready,
	input wire ld_valid,
	input wire ram_en,
	input wire ram_we,
	input wire [38:0] ram_wdata,
	input wire [31:0] pin_in,
	input wire [31:0] red_in,
	input wire [31:0] pri_out,
	input wire [31:0] red_out,
	input wire mismatch,
	input wire core_rst
);
default clocking @(posedge clk); endclocking
default disable iff (rst);
wire go = st_req && st_ready;
reg [1:0] up_r;
// Cycles since any reset, saturating
always @(posedge clk or posedge rst)
	if (rst) up_r <= 2'h0;
	else if (core_rst) up_r <= 2'h0;
	else if (up_r != 2'h3) up_r <= up_r + 2'h1;
AST_FULL: assert property (go && st_be == 4'hf |=> ram_en && ram_we)
	else $error("full store not written");
AST_RMW: assert property (go && st_be != 4'hf |=>
	ram_en && !ram_we && !st_ready ##1 !st_ready) else $error("slot freed");
AST_PAR: assert property (ram_we |-> !(^ram_wdata))
	else $error("bad check bits");
AST_LAG: assert property (!$past(rst) && !$past(rst, 2) |->
	red_in == $past(pin_in, 2)) else $error("copy inputs not lagged");
AST_DET: assert property (up_r == 2'h3 && !core_rst &&
	red_out != $past(pri_out, 2) |=> mismatch) else $error("miss");
AST_CAUSE: assert property ($rose(mismatch) |->
	$past(red_out) != $past(pri_out, 3)) else $error("false mismatch");
AST_JOINT: assert property ($rose(mismatch) |-> $rose(core_rst))
	else $error("no joint reset");
AST_HOLD: assert property ($rose(core_rst) |->
	(core_rst && mismatch) [*4] ##1 !core_rst && !mismatch) else $error("hold");
AST_PRIO: assert property (st_req |-> !ld_ready)
	else $error("load not held off by store");
AST_LOAD: assert property (ld_req && ld_ready |=>
	ram_en && !ram_we ##2 ld_valid) else $error("load answer late");
endmodule // lockstep_ecc_props
bind lockstep_ecc_protection lockstep_ecc_props chk_u (.*);

// [lockstep_far_model.sv]
// Data RAM and core pair model at the far side
`timescale 1ns/1ps
module lockstep_far_model (
	input wire clk,
	input wire ram_en,
	input wire ram_we,
	input wire [2:0] ram_addr,
	input wire [38:0] ram_wdata,
	output reg [38:0] ram_rdata,
	input wire [38:0] flip,
	input wire [31:0] red_in,
	input wire [31:0] pin_in,
	input wire core_rst,
	input wire inj,
	output wire [31:0] pri_out,
	output wire [31:0] red_out
);
reg [38:0] mem [0:7];
// Read one cycle late, scrambled when idle
always @(posedge clk) begin
	if (ram_en && ram_we) mem[ram_addr] <= ram_wdata;
	ram_rdata <= (ram_en && !ram_we) ? mem[ram_addr] ^ flip : ~ram_rdata;
end
assign pri_out = core_rst ? 32'h0 : pin_in + 32'h1;
assign red_out = core_rst ? 32'h0 : (red_in + 32'h1) ^ {31'h0, inj};
endmodule // lockstep_far_model

// [lockstep_ecc_protection_test.sv]
// Self-checking bench of the lock-step ECC block
`timescale 1ns/1ps
module lockstep_ecc_protection_test;
reg clk = 1'b0;
reg rst = 1'b1;
reg st_req = 1'b0;
reg ld_req = 1'b0;
reg inj = 1'b0;
reg rmw_seen = 1'b0;
reg [2:0] st_addr = 3'h0;
reg [2:0] ld_addr = 3'h0;
reg [31:0] st_wdata = 32'h0;
reg [31:0] pin_in = 32'h0;
reg [3:0] st_be = 4'hf;
reg [38:0] flip = 39'h0;
wire st_ready, ld_ready, ld_valid, ld_single_err, ld_double_err;
wire rmw_double_err, ram_en, ram_we, mismatch, core_rst;
wire [2:0] ram_addr;
wire [31:0] ld_data, red_in, pri_out, red_out;
wire [38:0] ram_wdata, ram_rdata;
integer fail_count = 0;
integer checks = 0;
integer i;
lockstep_ecc_protection dut_u (.*);
lockstep_far_model far_u (.*);
always #2.5 clk = ~clk;
always @(negedge clk) pin_in <= pin_in + 32'h01010101;
always @(posedge clk) if (rmw_double_err) rmw_seen <= 1'b1;
task chk(input [31:0] got, input [31:0] exp);
	begin
		checks = checks + 1;
		if (got !== exp) begin
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
			fail_count = fail_count + 1;
		end
	end
endtask
task st(input [2:0] a, input [31:0] d, input [3:0] b);
	begin
		{st_addr, st_wdata, st_be, st_req} = {a, d, b, 1'b1};
		while (!st_ready) @(negedge clk);
		@(negedge clk);
	end
endtask
task ld(input [2:0] a, input [31:0] d, input [1:0] e);
	begin
		{st_req, ld_req, ld_addr} = {2'b01, a};
		while (!ld_ready) @(negedge clk);
		@(negedge clk);
		ld_req = 1'b0;
		for (i = 0; i < 4 && !ld_valid; i = i + 1) @(negedge clk);
		chk(ld_valid, 1'b1);
		chk({ld_double_err, ld_single_err}, e);
		if (!e[1]) chk(ld_data, d);
	end
endtask
task t_store;
	begin
		st(3'h0, 32'h12345678, 4'hf);
		st(3'h7, 32'hfedcba98, 4'hf);
		ld(3'h0, 32'h12345678, 2'h0);
		ld(3'h7, 32'hfedcba98, 2'h0);
		$display("store test done");
	end
endtask
task t_partial;
	begin
		st(3'h3, 32'haabbccdd, 4'hf);
		st(3'h3, 32'h00000011, 4'h1);
		st(3'h3, 32'h22220000, 4'hc);
		ld(3'h3, 32'h2222cc11, 2'h0);
		st(3'h3, 32'h77777777, 4'h1);
		st(3'h3, 32'h55555555, 4'hf);
		ld(3'h3, 32'h55555555, 2'h0);
		$display("partial test done");
	end
endtask
task t_ecc;
	begin
		flip = 39'h1;
		ld(3'h3, 32'h55555555, 2'h1);
		flip = 39'h3;
		ld(3'h3, 32'h0, 2'h2);
		st(3'h3, 32'h000000ee, 4'h1);
		st_req = 1'b0;
		repeat (3) @(negedge clk);
		flip = 39'h0;
		chk(rmw_seen, 1'b1);
		ld(3'h3, 32'h55555555, 2'h0);
		$display("ecc test done");
	end
endtask
task t_lock;
	begin
		repeat (20) @(negedge clk);
		chk(mismatch, 1'b0);
		inj = 1'b1;
		@(negedge clk);
		inj = 1'b0;
		@(negedge clk);
		chk({mismatch, core_rst}, 2'h3);
		repeat (5) @(negedge clk);
		chk({mismatch, core_rst}, 2'h0);
		repeat (10) @(negedge clk);
		chk(mismatch, 1'b0);
		$display("lock test done");
	end
endtask
task results;
	begin
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
endtask
initial begin
	repeat (6) @(negedge clk);
	rst = 1'b0;
	t_store;
	t_partial;
	t_ecc;
	t_lock;
	results;
end
initial begin
	#20000;
	fail_count = fail_count + 1;
	results;
end
endmodule // lockstep_ecc_protection_test
